// >>> bench/dac_ch0_regs_chk.sv
// bound port checks for the channel 0 register block
`timescale 1ns/10ps
module dac_ch0_chk (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // sync reset, low
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic [1:0]  s_axi_bresp,   // b response
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic        step_a,        // a transfer
  input wire logic        count_end_a    // count end
);
  // ==========================================================
  // one clock domain for every check
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // answers hold until the master takes them
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  // no new request taken while an answer waits
  a_write_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("w taken busy");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar taken busy");
  // answers come a fixed time after the request is taken
  a_b_timing: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_awready, 2) ||
    $past(s_axi_wvalid && s_axi_wready, 2)) else $error("b off time");
  a_r_timing: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready)) else $error("r off time");
  // count end only two cycles after a transfer step
  a_end_cause: assert property (
    count_end_a |-> $past(step_a, 2)) else $error("end without step");
  // count end is a single pulse without a further step
  a_end_pulse: assert property (
    count_end_a && !$past(step_a) |=> !count_end_a)
    else $error("end held");
endmodule

bind dac_ch0_regs dac_ch0_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .step_a(step_a),
  .count_end_a(count_end_a));

// >>> bench/tb_top.sv
// self-checking bench for the channel 0 address and count registers
`timescale 1ns/10ps
module tb_top;
  // ==========================================================
  // signals
  logic        aclk, aresetn;                 // clock, reset
  logic [17:0] awaddr, araddr;                // byte addresses
  logic [31:0] wdata, rdata, d;               // data
  logic [3:0]  wstrb;                         // lanes
  logic [1:0]  bresp, rresp;                  // responses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        step_a, step_b, count_end_a;   // transfer side
  logic [23:0] src_a, dst_a, src_b, dst_b;    // address outputs
  int          errors, checks_done;           // tallies

  dac_ch0_regs dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .step_a(step_a), .step_b(step_b),
    .src_addr_a(src_a), .dst_addr_a(dst_a), .src_addr_b(src_b),
    .dst_addr_b(dst_b), .count_end_a(count_end_a));

  // ==========================================================
  // clock, 50 ns period
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // one write, both halves offered together
  task automatic wr(input logic [15:0] i, input logic [31:0] v,
      input logic [3:0] s = 4'h3,
      input logic [1:0] er = dac_pkg::RESP_OKAY);
    @(posedge aclk);
    awaddr <= {i, dac_pkg::IDX_PAD};
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(er));
    // address outputs trail the registers by one edge: let them settle
    @(posedge aclk);
    #1;
  endtask

  // one read, data left in d
  task automatic rd(input logic [15:0] i,
      input logic [1:0] er = dac_pkg::RESP_OKAY);
    @(posedge aclk);
    araddr <= {i, dac_pkg::IDX_PAD};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rready <= 1'b0;
    check("rresp", 32'(rresp), 32'(er));
  endtask

  // one step pulse, count end looked at two cycles on
  task automatic pulse(input logic a, b, e);
    @(posedge aclk);
    step_a <= a;
    step_b <= b;
    @(posedge aclk);
    step_a <= 1'b0;
    step_b <= 1'b0;
    @(posedge aclk);
    #1;
    check("count_end_a", 32'(count_end_a), 32'(e));
  endtask

  // ends the run with the verdict
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // short mode ends, high register keeps only its low byte
  task automatic t_short;
    wr(dac_pkg::IDX_MAR_AH, 32'h0000AB12);
    wr(dac_pkg::IDX_MAR_AL, 32'h00003456);
    wr(dac_pkg::IDX_IO_A, 32'h00005678);
    wr(dac_pkg::IDX_MAR_BH, 32'h0000009A);
    wr(dac_pkg::IDX_MAR_BL, 32'h0000BCDE);
    wr(dac_pkg::IDX_IO_B, 32'h00001357);
    rd(dac_pkg::IDX_MAR_AH);
    check("mar_a_high", d, 32'h00000012);
    check("src_a", 32'(src_a), 32'h00123456);
    check("dst_a", 32'(dst_a), 32'h00FF5678);
    check("src_b", 32'(src_b), 32'h009ABCDE);
    check("dst_b", 32'(dst_b), 32'h00FF1357);
    wr(dac_pkg::IDX_CTRL, 32'h0000000E, 4'h1);
    check("src_a", 32'(src_a), 32'h00FF5678);
    check("dst_a", 32'(dst_a), 32'h00123456);
    pulse(1'b0, 1'b1, 1'b0);
    check("dst_b", 32'(dst_b), 32'h009ABCDF);
  endtask

  // full mode: a is source, b destination, i/o ignored
  task automatic t_full;
    wr(dac_pkg::IDX_CTRL, 32'h00000009, 4'h1);
    wr(dac_pkg::IDX_IO_A, 32'h0000FFFF);
    check("src_a", 32'(src_a), 32'h00123456);
    check("dst_a", 32'(dst_a), 32'h009ABCDF);
    check("src_b", 32'(src_b), 32'h00000000);
    check("dst_b", 32'(dst_b), 32'h00000000);
    pulse(1'b1, 1'b0, 1'b0);
    check("src_a", 32'(src_a), 32'h00123457);
    check("dst_a", 32'(dst_a), 32'h009ABCE0);
  endtask

  // every count mode, then the done flag and its clearing
  task automatic t_count;
    logic rep;
    for (int m = 0; m < 5; m++) begin
      rep = (m > 2);
      wr(dac_pkg::IDX_CTRL, 32'(m << 4), 4'h1);
      wr(dac_pkg::IDX_TC_A, rep ? 32'h00000301 : 32'h00000002);
      pulse(1'b1, 1'b0, rep);
      pulse(1'b1, 1'b0, !rep);
      rd(dac_pkg::IDX_TC_A);
      check("count", d, rep ? 32'h00000302 : 32'h00000000);
    end
    rd(dac_pkg::IDX_CTRL);
    check("ctrl", d, 32'h00000140);
    wr(dac_pkg::IDX_CTRL, 32'h00000100, 4'h2);
    rd(dac_pkg::IDX_CTRL);
    check("ctrl", d, 32'h00000040);
  endtask

  // unmapped places answer with an error
  task automatic t_bad;
    rd(16'h0000, dac_pkg::RESP_SLVERR);
    check("unmapped", d, 32'h00000000);
    wr(16'h0001, 32'h0000FFFF, 4'h3, dac_pkg::RESP_SLVERR);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    {aresetn, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, step_a, step_b} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(dac_pkg::IDX_MAR_AL);
    check("reset", d, 32'h00000000);
    t_short;
    t_full;
    t_count;
    t_bad;
    complete_run;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    complete_run;
  end
endmodule

// >>> verilog/dac_ch0_regs.sv
// channel 0 address and transfer count registers with axi4-lite access
// Function
// - short mode: memory and i/o address form ends
// - full mode: a memory address is source
// - full mode: b memory address is destination
// - full mode: i/o addresses ignored
`timescale 1ns/10ps
module dac_ch0_regs #(
  parameter logic [7:0] IO_PAGE = dac_pkg::IO_PAGE_DEF // i/o page bits
) (
  input  wire logic        aclk,               // system clock
  input  wire logic        aresetn,            // sync reset, active low
  input  wire logic [17:0] s_axi_awaddr,       // write address
  input  wire logic        s_axi_awvalid,      // write address valid
  output logic             s_axi_awready,      // write address ready
  input  wire logic [31:0] s_axi_wdata,        // write data
  input  wire logic [3:0]  s_axi_wstrb,        // write strobes
  input  wire logic        s_axi_wvalid,       // write data valid
  output logic             s_axi_wready,       // write data ready
  output logic [1:0]       s_axi_bresp,        // write response
  output logic             s_axi_bvalid,       // write response valid
  input  wire logic        s_axi_bready,       // write response ready
  input  wire logic [17:0] s_axi_araddr,       // read address
  input  wire logic        s_axi_arvalid,      // read address valid
  output logic             s_axi_arready,      // read address ready
  output logic [31:0]      s_axi_rdata,        // read data
  output logic [1:0]       s_axi_rresp,        // read response
  output logic             s_axi_rvalid,       // read data valid
  input  wire logic        s_axi_rready,       // read data ready
  input  wire logic        step_a,             // sub-channel a transfer
  input  wire logic        step_b,             // sub-channel b transfer
  output logic [23:0]      src_addr_a,         // a source address
  output logic [23:0]      dst_addr_a,         // a destination address
  output logic [23:0]      src_addr_b,         // b source address
  output logic [23:0]      dst_addr_b,         // b destination address
  output logic             count_end_a         // count end pulse
);

  // ==========================================================
  // helpers
  // byte address of a register index
  function automatic logic [17:0] baddr(input logic [15:0] idx);
    baddr = {idx, dac_pkg::IDX_PAD};
  endfunction

  // register select from a byte address
  function automatic dac_pkg::dac_rsel_t decode(input logic [17:0] a);
    if (a == baddr(dac_pkg::IDX_MAR_AH))      decode = dac_pkg::RS_MAR_AH;
    else if (a == baddr(dac_pkg::IDX_MAR_AL)) decode = dac_pkg::RS_MAR_AL;
    else if (a == baddr(dac_pkg::IDX_CTRL))   decode = dac_pkg::RS_CTRL;
    else if (a == baddr(dac_pkg::IDX_IO_A))   decode = dac_pkg::RS_IO_A;
    else if (a == baddr(dac_pkg::IDX_TC_A))   decode = dac_pkg::RS_TC_A;
    else if (a == baddr(dac_pkg::IDX_MAR_BH)) decode = dac_pkg::RS_MAR_BH;
    else if (a == baddr(dac_pkg::IDX_MAR_BL)) decode = dac_pkg::RS_MAR_BL;
    else if (a == baddr(dac_pkg::IDX_IO_B))   decode = dac_pkg::RS_IO_B;
    else                                      decode = dac_pkg::RS_NONE;
  endfunction

  // byte lane merge of a 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  strb);
    merge16 = old;
    if (strb[0]) merge16[7:0]  = nw[7:0];
    if (strb[1]) merge16[15:8] = nw[15:8];
  endfunction

  // ==========================================================
  // state
  logic [17:0] aw_addr_q;                      // held write address
  logic        aw_full_q;                      // write address held
  logic [31:0] w_data_q;                       // held write data
  logic [3:0]  w_strb_q;                       // held write strobes
  logic        w_full_q;                       // write data held
  logic        awready_q;                      // address ready
  logic        wready_q;                       // data ready
  logic        bvalid_q;                       // response pending
  logic [1:0]  bresp_q;                        // response code
  logic        arready_q;                      // read address ready
  logic        rvalid_q;                       // read data pending
  logic [31:0] rdata_q;                        // read data
  logic [1:0]  rresp_q;                        // read response
  logic [23:0] mar_a_q;                        // ch0a memory address
  logic [23:0] mar_b_q;                        // ch0b memory address
  logic [15:0] io_a_q;                         // ch0a peripheral address
  logic [15:0] io_b_q;                         // ch0b peripheral address
  logic [6:0]  ctrl_q;                         // mode control bits
  logic        done_q;                         // sticky count end
  logic [23:0] src_a_q;                        // a source output
  logic [23:0] dst_a_q;                        // a destination output
  logic [23:0] src_b_q;                        // b source output
  logic [23:0] dst_b_q;                        // b destination output
  logic        cend_q;                         // count end output
  logic        do_write;                       // both halves present
  dac_pkg::dac_rsel_t wsel;                    // write register select
  dac_pkg::dac_rsel_t rsel;                    // read register select
  logic        full_mode;                      // full address mode
  logic        inc_en;                         // address increment on

  dac_cnt_if cnt ();                           // count unit link

  assign do_write  = aw_full_q & w_full_q & ~bvalid_q;
  assign wsel      = decode(aw_addr_q);
  assign rsel      = decode(s_axi_araddr);
  assign full_mode = ctrl_q[dac_pkg::CTL_FULL];
  assign inc_en    = ctrl_q[dac_pkg::CTL_INC];

  // ==========================================================
  // axi write channels
  // address and data are held independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      awready_q <= 1'b0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      awready_q <= 1'b0;
    end else begin
      if (do_write) aw_full_q <= 1'b0;
      awready_q <= ~aw_full_q & ~bvalid_q;
    end
  end

  // write data holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      wready_q <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      wready_q <= 1'b0;
    end else begin
      if (do_write) w_full_q <= 1'b0;
      wready_q <= ~w_full_q & ~bvalid_q;
    end
  end

  // write response, error for an unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= dac_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wsel == dac_pkg::RS_NONE) ? dac_pkg::RESP_SLVERR
                                             : dac_pkg::RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // axi read channels
  // one cycle from address handshake to read data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= dac_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= dac_pkg::RESP_OKAY;
      rdata_q   <= '0;
      case (rsel)
        dac_pkg::RS_MAR_AH: rdata_q[7:0]  <= mar_a_q[23:16];
        dac_pkg::RS_MAR_AL: rdata_q[15:0] <= mar_a_q[15:0];
        dac_pkg::RS_CTRL:   rdata_q[8:0]  <= {done_q, 1'b0, ctrl_q};
        dac_pkg::RS_IO_A:   rdata_q[15:0] <= io_a_q;
        dac_pkg::RS_TC_A:   rdata_q[15:0] <= cnt.count;
        dac_pkg::RS_MAR_BH: rdata_q[7:0]  <= mar_b_q[23:16];
        dac_pkg::RS_MAR_BL: rdata_q[15:0] <= mar_b_q[15:0];
        dac_pkg::RS_IO_B:   rdata_q[15:0] <= io_b_q;
        default:            rresp_q       <= dac_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else begin
      arready_q <= ~rvalid_q;
    end
  end

  // ==========================================================
  // memory address registers
  // software write wins over an increment in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mar_a_q <= dac_pkg::MAR_RESET;
    end else if (do_write && wsel == dac_pkg::RS_MAR_AH) begin
      if (w_strb_q[0]) mar_a_q[23:16] <= w_data_q[7:0];
    end else if (do_write && wsel == dac_pkg::RS_MAR_AL) begin
      mar_a_q[15:0] <= merge16(mar_a_q[15:0], w_data_q[15:0],
                               w_strb_q[1:0]);
    end else if (step_a && inc_en) begin
      mar_a_q <= mar_a_q + dac_pkg::MAR_ONE;
    end
  end

  // b address steps with a in full mode, with b in short mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mar_b_q <= dac_pkg::MAR_RESET;
    end else if (do_write && wsel == dac_pkg::RS_MAR_BH) begin
      if (w_strb_q[0]) mar_b_q[23:16] <= w_data_q[7:0];
    end else if (do_write && wsel == dac_pkg::RS_MAR_BL) begin
      mar_b_q[15:0] <= merge16(mar_b_q[15:0], w_data_q[15:0],
                               w_strb_q[1:0]);
    end else if ((full_mode ? step_a : step_b) && inc_en) begin
      mar_b_q <= mar_b_q + dac_pkg::MAR_ONE;
    end
  end

  // peripheral address registers, fixed during transfers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_a_q <= dac_pkg::REG_RESET;
      io_b_q <= dac_pkg::REG_RESET;
    end else if (do_write && wsel == dac_pkg::RS_IO_A) begin
      io_a_q <= merge16(io_a_q, w_data_q[15:0], w_strb_q[1:0]);
    end else if (do_write && wsel == dac_pkg::RS_IO_B) begin
      io_b_q <= merge16(io_b_q, w_data_q[15:0], w_strb_q[1:0]);
    end
  end

  // ==========================================================
  // control register and sticky count end flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= dac_pkg::CTL_RESET;
    end else if (do_write && wsel == dac_pkg::RS_CTRL && w_strb_q[0]) begin
      ctrl_q <= w_data_q[6:0];
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (cnt.term) begin
      done_q <= 1'b1;
    end else if (do_write && wsel == dac_pkg::RS_CTRL && w_strb_q[1] &&
                 w_data_q[dac_pkg::CTL_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // ==========================================================
  // transfer count unit
  assign cnt.load      = do_write && (wsel == dac_pkg::RS_TC_A);
  assign cnt.load_data = w_data_q[15:0];
  assign cnt.load_strb = w_strb_q[1:0];
  assign cnt.step      = step_a;
  assign cnt.mode      = dac_pkg::dac_cmode_t'(
                           ctrl_q[dac_pkg::CTL_MODE_H:dac_pkg::CTL_MODE_L]);

  dac_count_unit u_count (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cnt.unit)
  );

  // ==========================================================
  // address generation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_a_q <= dac_pkg::MAR_RESET;
      dst_a_q <= dac_pkg::MAR_RESET;
      src_b_q <= dac_pkg::MAR_RESET;
      dst_b_q <= dac_pkg::MAR_RESET;
    end else if (full_mode) begin
      src_a_q <= mar_a_q;
      dst_a_q <= mar_b_q;
      src_b_q <= dac_pkg::MAR_RESET;
      dst_b_q <= dac_pkg::MAR_RESET;
    end else begin
      // direction bit picks which end the i/o address takes
      if (ctrl_q[dac_pkg::CTL_DIR_A]) begin
        src_a_q <= {IO_PAGE, io_a_q};
        dst_a_q <= mar_a_q;
      end else begin
        src_a_q <= mar_a_q;
        dst_a_q <= {IO_PAGE, io_a_q};
      end
      if (ctrl_q[dac_pkg::CTL_DIR_B]) begin
        src_b_q <= {IO_PAGE, io_b_q};
        dst_b_q <= mar_b_q;
      end else begin
        src_b_q <= mar_b_q;
        dst_b_q <= {IO_PAGE, io_b_q};
      end
    end
  end

  // count end pulse out, one cycle after the unit's
  always_ff @(posedge aclk) begin
    if (!aresetn) cend_q <= 1'b0;
    else          cend_q <= cnt.term;
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign src_addr_a    = src_a_q;
  assign dst_addr_a    = dst_a_q;
  assign src_addr_b    = src_b_q;
  assign dst_addr_b    = dst_b_q;
  assign count_end_a   = cend_q;

endmodule

// >>> verilog/dac_cnt_if.sv
// link between the register block and its transfer count unit
`timescale 1ns/10ps
interface dac_cnt_if;
  logic                 load;                  // software write pulse
  logic [15:0]          load_data;             // written value
  logic [1:0]           load_strb;             // byte lanes written
  logic                 step;                  // one transfer done
  dac_pkg::dac_cmode_t  mode;                  // count mode
  logic [15:0]          count;                 // current contents
  logic                 term;                  // count end pulse

  modport regs (output load, load_data, load_strb, step, mode,
                input count, term);
  modport unit (input load, load_data, load_strb, step, mode,
                output count, term);
endinterface

// >>> verilog/dac_count_unit.sv
// transfer count register with its mode dependent counting
`timescale 1ns/10ps
module dac_count_unit (
  input  wire logic  aclk,                     // system clock
  input  wire logic  aresetn,                  // sync reset, active low
  dac_cnt_if.unit    cif                       // register side link
);

  logic [15:0] count_q;                        // count register
  logic        term_q;                         // count end pulse

  // ==========================================================
  // counting
  // software load wins over a step in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= dac_pkg::REG_RESET;
      term_q  <= 1'b0;
    end else if (cif.load) begin
      if (cif.load_strb[0]) begin
        count_q[7:0] <= cif.load_data[7:0];
      end
      if (cif.load_strb[1]) begin
        count_q[15:8] <= cif.load_data[15:8];
      end
      term_q <= 1'b0;
    end else if (cif.step) begin
      case (cif.mode)
        // high byte reload number, low byte counter
        dac_pkg::CM_REPEAT, dac_pkg::CM_BLOCK: begin
          if (count_q[7:0] == dac_pkg::BYTE_ONE) begin
            count_q[7:0] <= count_q[15:8];
            term_q       <= 1'b1;
          end else begin
            count_q[7:0] <= count_q[7:0] - dac_pkg::BYTE_ONE;
            term_q       <= 1'b0;
          end
        end
        // full 16-bit counter in the other modes
        default: begin
          count_q <= count_q - dac_pkg::WORD_ONE;
          term_q  <= (count_q == dac_pkg::WORD_ONE);
        end
      endcase
    end else begin
      term_q <= 1'b0;
    end
  end

  assign cif.count = count_q;
  assign cif.term  = term_q;

endmodule

// >>> verilog/dac_pkg.sv
// shared constants and types for the channel 0 address and count registers
package dac_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W   = 18;       // axi byte address width
  localparam int unsigned DATA_W   = 32;       // axi data width
  localparam int unsigned REG_W    = 16;       // register width
  localparam int unsigned MAR_W    = 24;       // memory address width
  localparam int unsigned IOP_W    = 8;        // i/o page width
  localparam int unsigned BYTE_W   = 8;        // one byte

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_MAR_AH = 16'hFEE0; // ch0a memory addr high
  localparam logic [15:0] IDX_MAR_AL = 16'hFEE2; // ch0a memory addr low
  localparam logic [15:0] IDX_CTRL   = 16'hFEE3; // mode control and status
  localparam logic [15:0] IDX_IO_A   = 16'hFEE4; // ch0a peripheral addr
  localparam logic [15:0] IDX_TC_A   = 16'hFEE6; // ch0a transfer count
  localparam logic [15:0] IDX_MAR_BH = 16'hFEE8; // ch0b memory addr high
  localparam logic [15:0] IDX_MAR_BL = 16'hFEEA; // ch0b memory addr low
  localparam logic [15:0] IDX_IO_B   = 16'hFEEC; // ch0b peripheral addr
  localparam logic [1:0]  IDX_PAD    = 2'h0;     // word alignment bits

  // ==========================================================
  // control register fields
  localparam int unsigned CTL_FULL   = 0;      // 1: full address mode
  localparam int unsigned CTL_DIR_A  = 1;      // short a: 1 = i/o is source
  localparam int unsigned CTL_DIR_B  = 2;      // short b: 1 = i/o is source
  localparam int unsigned CTL_INC    = 3;      // memory address increments
  localparam int unsigned CTL_MODE_L = 4;      // count mode field low bit
  localparam int unsigned CTL_MODE_H = 6;      // count mode field high bit
  localparam int unsigned CTL_DONE   = 8;      // sticky count end, w1c
  localparam logic [6:0]  CTL_RESET  = 7'h00;  // control reset value

  // ==========================================================
  // reset values and constants
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000; // register reset
  localparam logic [MAR_W-1:0] MAR_RESET = 24'h000000;
  localparam logic [MAR_W-1:0] MAR_ONE   = 24'h000001; // address step
  localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;    // count step
  localparam logic [REG_W-1:0] WORD_ONE  = 16'h0001; // count step
  localparam logic [IOP_W-1:0] IO_PAGE_DEF = 8'hFF;  // i/o page default
  localparam logic [1:0] RESP_OKAY   = 2'h0;   // axi okay
  localparam logic [1:0] RESP_SLVERR = 2'h2;   // axi slave error

  // ==========================================================
  // transfer count modes
  typedef enum logic [2:0] {
    CM_SEQ    = 3'h0,                          // sequential
    CM_IDLE   = 3'h1,                          // idle
    CM_NORMAL = 3'h2,                          // normal
    CM_REPEAT = 3'h3,                          // repeat
    CM_BLOCK  = 3'h4                           // block transfer
  } dac_cmode_t;

  // register select produced by the address decoder
  typedef enum logic [3:0] {
    RS_MAR_AH = 4'h0,
    RS_MAR_AL = 4'h1,
    RS_CTRL   = 4'h2,
    RS_IO_A   = 4'h3,
    RS_TC_A   = 4'h4,
    RS_MAR_BH = 4'h5,
    RS_MAR_BL = 4'h6,
    RS_IO_B   = 4'h7,
    RS_NONE   = 4'hF
  } dac_rsel_t;

endpackage
